// [rtl/cmd_port.sv]
/*
  Two-wire slave command port: address match, sub-address decode,
  16-bit control and data registers, clock stretching toward firmware.
  Assumes synchronous bus inputs and an external open-drain pad that
  pulls low whenever an *_oe_n output is low.
*/
`timescale 1ns/1ps
`include "cmd_port_map.svh"
module cmd_port import cmd_port_pkg::*; #(
  parameter int RESP_MAX_CYC = `RESP_MAX_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic core_enable_a,
  input wire logic core_enable_b,
  output logic [15:0] cmd_word,
  output logic cmd_valid,
  input wire logic cmd_taken,
  input wire logic [15:0] rd_word,
  input wire logic rd_load,
  output logic rd_request,
  output logic soft_reset,
  output logic [3:0] task_select_field
);
  logic scl_rise, scl_fall, start_cond, stop_cond, sda_level;

  port_state_t state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sub_reg, sub_next;
  logic [7:0] hi_reg, hi_next;
  logic idx_reg, idx_next;
  logic rw_reg, rw_next;
  logic sda_drv_reg, sda_drv_next;
  logic scl_drv_next;
  logic [15:0] cmd_word_next;
  logic cmd_valid_next;
  logic [15:0] rd_hold_reg, rd_hold_next;
  logic rd_avail_reg, rd_avail_next;
  logic rd_request_next;
  logic soft_reset_next;
  logic [3:0] task_next;
  logic [31:0] hold_cnt_reg, hold_cnt_next;
  logic cores_on;
  logic hold_timeout;

  bus_edge_detect u_edges (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_cond(start_cond),
    .stop_cond(stop_cond),
    .sda_level(sda_level)
  );

  // Processor must run for the port to ack its address; later bytes are not gated
  assign cores_on = core_enable_a & core_enable_b;
  // Give up stretching if firmware misses its worst case
  assign hold_timeout = (hold_cnt_reg >= 32'(RESP_MAX_CYC - 1));

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    sub_next = sub_reg;
    hi_next = hi_reg;
    idx_next = idx_reg;
    rw_next = rw_reg;
    sda_drv_next = sda_drv_reg;
    scl_drv_next = 1'b0;
    cmd_word_next = cmd_word;
    cmd_valid_next = cmd_valid;
    rd_hold_next = rd_hold_reg;
    rd_avail_next = rd_avail_reg;
    soft_reset_next = 1'b0;
    task_next = task_select_field;
    hold_cnt_next = 32'h0000_0000;

    if (cmd_taken) begin
      cmd_valid_next = 1'b0;
    end

    if (stop_cond) begin
      state_next = ST_IDLE;
      sda_drv_next = 1'b0;
    end else if (start_cond) begin
      // Repeated start keeps the stored sub-address
      state_next = ST_ADDR;
      cnt_next = 4'h0;
      sda_drv_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_ADDR, ST_SUB, ST_WR: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_level};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            cnt_next = 4'h0;
            if (state_reg == ST_ADDR) begin
              // Reads only after the read sub-address
              if (shift_reg[7:1] == `DEV_ADDR && cores_on &&
                  (!shift_reg[0] || sub_reg == `SUB_DATA_RD)) begin
                rw_next = shift_reg[0];
                sda_drv_next = 1'b1;
                state_next = ST_ADDR_ACK;
              end else begin
                state_next = ST_IDLE;
              end
            end else if (state_reg == ST_SUB) begin
              if (shift_reg == `SUB_DATA_WR || shift_reg == `SUB_DATA_RD ||
                  shift_reg == `SUB_CTRL) begin
                sub_next = shift_reg;
                sda_drv_next = 1'b1;
                state_next = ST_SUB_ACK;
              end else begin
                state_next = ST_IDLE;
              end
            end else if (sub_reg == `SUB_DATA_RD) begin
              state_next = ST_IDLE;
            end else if (!idx_reg) begin
              hi_next = shift_reg;
              sda_drv_next = 1'b1;
              state_next = ST_WR_ACK;
            end else if (sub_reg == `SUB_DATA_WR && cmd_valid_next) begin
              // Firmware has not drained the last word yet
              scl_drv_next = 1'b1;
              state_next = ST_HOLD_W;
            end else begin
              sda_drv_next = 1'b1;
              state_next = ST_WR_ACK;
              if (sub_reg == `SUB_DATA_WR) begin
                cmd_word_next = {hi_reg, shift_reg};
                cmd_valid_next = 1'b1;
              end else begin
                // Upper bits don't care, 7..4 unused
                soft_reset_next = hi_reg[`CTRL_RESET_BIT - 8];
                task_next = shift_reg[`CTRL_TASK_MSB:0];
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            sda_drv_next = 1'b0;
            idx_next = 1'b0;
            cnt_next = 4'h0;
            if (!rw_reg) begin
              state_next = ST_SUB;
            end else if (rd_avail_reg) begin
              shift_next = rd_hold_reg[15:8];
              sda_drv_next = ~rd_hold_reg[15];
              state_next = ST_RD;
            end else begin
              scl_drv_next = 1'b1;
              state_next = ST_HOLD_R;
            end
          end
        end
        ST_SUB_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            sda_drv_next = 1'b0;
            cnt_next = 4'h0;
            // Words may follow back to back
            idx_next = (state_reg == ST_WR_ACK) ? ~idx_reg : 1'b0;
            state_next = ST_WR;
          end
        end
        ST_HOLD_W: begin
          scl_drv_next = 1'b1;
          hold_cnt_next = hold_cnt_reg + 32'h0000_0001;
          if (!cmd_valid) begin
            // Clock stays low one more cycle so ack leads its release
            cmd_word_next = {hi_reg, shift_reg};
            cmd_valid_next = 1'b1;
            sda_drv_next = 1'b1;
            state_next = ST_WR_ACK;
          end else if (hold_timeout) begin
            scl_drv_next = 1'b0;
            state_next = ST_IDLE;
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
              sda_drv_next = 1'b0;
              state_next = ST_RD_ACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              sda_drv_next = ~shift_reg[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise && sda_level) begin
            state_next = ST_IDLE; // Master ends the read
          end else if (scl_fall) begin
            cnt_next = 4'h0;
            if (!idx_reg) begin
              idx_next = 1'b1;
              shift_next = rd_hold_reg[7:0];
              sda_drv_next = ~rd_hold_reg[7];
              rd_avail_next = 1'b0;
              state_next = ST_RD;
            end else if (rd_avail_reg) begin
              idx_next = 1'b0;
              shift_next = rd_hold_reg[15:8];
              sda_drv_next = ~rd_hold_reg[15];
              state_next = ST_RD;
            end else begin
              idx_next = 1'b0;
              scl_drv_next = 1'b1;
              state_next = ST_HOLD_R;
            end
          end
        end
        ST_HOLD_R: begin
          scl_drv_next = 1'b1;
          hold_cnt_next = hold_cnt_reg + 32'h0000_0001;
          if (rd_avail_reg) begin
            shift_next = rd_hold_reg[15:8];
            sda_drv_next = ~rd_hold_reg[15];
            state_next = ST_RD;
          end else if (hold_timeout) begin
            scl_drv_next = 1'b0;
            state_next = ST_IDLE;
          end
        end
        default: begin
          state_next = ST_IDLE;
          sda_drv_next = 1'b0;
        end
      endcase
    end

    // A fresh firmware word wins over the consume in the same cycle
    if (rd_load) begin
      rd_hold_next = rd_word;
      rd_avail_next = 1'b1;
    end
    rd_request_next = (state_next == ST_HOLD_R);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      cnt_reg <= 4'h0;
      sub_reg <= 8'h00;
      hi_reg <= 8'h00;
      idx_reg <= 1'b0;
      rw_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      cmd_word <= 16'h0000;
      cmd_valid <= 1'b0;
      rd_hold_reg <= 16'h0000;
      rd_avail_reg <= 1'b0;
      rd_request <= 1'b0;
      soft_reset <= 1'b0;
      task_select_field <= 4'h0;
      hold_cnt_reg <= 32'h0000_0000;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (ce) begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      sub_reg <= sub_next;
      hi_reg <= hi_next;
      idx_reg <= idx_next;
      rw_reg <= rw_next;
      sda_drv_reg <= sda_drv_next;
      cmd_word <= cmd_word_next;
      cmd_valid <= cmd_valid_next;
      rd_hold_reg <= rd_hold_next;
      rd_avail_reg <= rd_avail_next;
      rd_request <= rd_request_next;
      soft_reset <= soft_reset_next;
      task_select_field <= task_next;
      hold_cnt_reg <= hold_cnt_next;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      // Open drain: only ever pull low
      scl_oe_n <= ~scl_drv_next;
      sda_oe_n <= ~sda_drv_next;
    end
  end
endmodule // cmd_port

// [rtl/cmd_port_map.svh]
/*
  Offsets, field positions and timing counts of the two-wire command port.
  Assumes a 250 MHz core clock; included by bare name.
*/
// Behaviour
// - Slave only, transfer words of 16 bits
// - Answer address 0011101, last bit selects direction
// - Stretch clock low when device needs time
// - Each register access moves two bytes, high first
// - Decode three sub-addresses: data write, read, control
// - Control goes to reset/task; others carry data
// - Control register is write-only, never read back
// - Bit 8 set triggers soft reset; upper ignored
// - Data register read/write, most significant bit first
// - Commands run without stalling audio data streams
// - Firmware answers within 4 ms worst case
// - Internal 20-bit values are two's complement fractions
`ifndef CMD_PORT_MAP_SVH
`define CMD_PORT_MAP_SVH

`define DEV_ADDR 7'h1D
`define SUB_DATA_WR 8'h68
`define SUB_DATA_RD 8'h69
`define SUB_CTRL 8'h6A
`define CTRL_RESET_BIT 8
`define CTRL_TASK_MSB 3
`define WORD_BITS 16
`define CLK_MHZ 250
`define RESP_MAX_MS 4
`define RESP_MAX_CYC (`RESP_MAX_MS * 1000 * `CLK_MHZ)

`endif

// [rtl/cmd_port_pkg.sv]
/*
  Types of the two-wire command port.
  Assumes cmd_port_map.svh supplies the numeric constants.
*/
package cmd_port_pkg;

  // Gray codes along address, sub-address and write ack loop; hold states and read entry break the one-bit steps
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_SUB      = 4'h2,
    ST_SUB_ACK  = 4'h6,
    ST_WR       = 4'h7,
    ST_WR_ACK   = 4'h5,
    ST_HOLD_W   = 4'hD,
    ST_RD       = 4'h4,
    ST_RD_ACK   = 4'hC,
    ST_HOLD_R   = 4'hE
  } port_state_t;

  // Fraction v maps to v*2^19 rounded
  typedef logic signed [19:0] fixed20_t;

endpackage

// [rtl/bus_edge_detect.sv]
/*
  Edge and start/stop detector for the serial clock and data lines.
  Assumes both lines are already synchronous to clk.
*/
`timescale 1ns/1ps
module bus_edge_detect (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_cond,
  output logic stop_cond,
  output logic sda_level
);
  logic scl_q_reg, sda_q_reg;
  logic scl_q_next, sda_q_next;
  logic rise_next, fall_next, start_next, stop_next;

  always_comb begin
    scl_q_next = scl_in;
    sda_q_next = sda_in;
    rise_next = scl_in & ~scl_q_reg;
    fall_next = ~scl_in & scl_q_reg;
    // Data moving while clock is high marks frame bounds
    start_next = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
    stop_next = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      scl_rise <= 1'b0;
      scl_fall <= 1'b0;
      start_cond <= 1'b0;
      stop_cond <= 1'b0;
      sda_level <= 1'b1;
    end else if (ce) begin
      scl_q_reg <= scl_q_next;
      sda_q_reg <= sda_q_next;
      scl_rise <= rise_next;
      scl_fall <= fall_next;
      start_cond <= start_next;
      stop_cond <= stop_next;
      sda_level <= sda_q_reg;
    end
  end
endmodule // bus_edge_detect

// [bench/cmd_port_props.sv]
/*
  Concurrent checks on the command port pins, bound into cmd_port.
  Assumes ce stays high while the bus is in use.
*/
`timescale 1ns/1ps
module cmd_port_props import cmd_port_pkg::*; #(
  parameter int RESP_MAX_CYC = 1000000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic core_enable_a,
  input wire logic core_enable_b,
  input wire logic [15:0] cmd_word,
  input wire logic cmd_valid,
  input wire logic cmd_taken,
  input wire logic rd_request,
  input wire logic soft_reset
);
  int hold_reg;
  int hold_next;
  // Length of the current stretch; a stuck slave shows up here
  always_comb begin
    hold_next = scl_oe_n ? 0 : hold_reg + 1;
  end
  always_ff @(posedge clk) begin
    hold_reg <= reset_n ? hold_next : 0;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_cores_off;
    (!core_enable_a || !core_enable_b) [*8];
  endsequence
  sequence s_delivered;
    $rose(cmd_valid);
  endsequence
  property p_cores_gate; s_cores_off |-> sda_oe_n; endproperty
  a_cores_gate: assert property (p_cores_gate)
    else $error("acked with cores off");
  property p_deliver_ack; s_delivered |-> !sda_oe_n; endproperty
  a_deliver_ack: assert property (p_deliver_ack)
    else $error("word delivered without ack");
  property p_soft_pulse; soft_reset |=> !soft_reset [*4]; endproperty
  a_soft_pulse: assert property (p_soft_pulse)
    else $error("soft reset not a single pulse");
  property p_hold_valid; cmd_valid && !cmd_taken |=> cmd_valid; endproperty
  a_hold_valid: assert property (p_hold_valid)
    else $error("command dropped before taken");
  property p_word_stable;
    cmd_valid && !cmd_taken |=> $stable(cmd_word);
  endproperty
  a_word_stable: assert property (p_word_stable)
    else $error("pending command word changed");
  property p_sda_scl_low; $changed(sda_oe_n) |-> !scl_in; endproperty
  a_sda_scl_low: assert property (p_sda_scl_low)
    else $error("data line moved while clock high");
  property p_stretch_req; $rose(rd_request) |-> !scl_oe_n; endproperty
  a_stretch_req: assert property (p_stretch_req)
    else $error("read wait without stretch");
  property p_stretch_cap; hold_reg <= RESP_MAX_CYC + 4; endproperty
  a_stretch_cap: assert property (p_stretch_cap)
    else $error("stretch too long");
endmodule // cmd_port_props

bind cmd_port cmd_port_props #(.RESP_MAX_CYC(RESP_MAX_CYC)) u_props (
  .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .scl_oe_n(scl_oe_n),
  .sda_oe_n(sda_oe_n), .core_enable_a(core_enable_a),
  .core_enable_b(core_enable_b), .cmd_word(cmd_word),
  .cmd_valid(cmd_valid), .cmd_taken(cmd_taken),
  .rd_request(rd_request), .soft_reset(soft_reset)
);

// [bench/ctrl_master.sv]
/*
  Bus master model: start, stop and byte moves with ack.
  Assumes the bench wires both lines open-drain with pull-ups.
*/
`timescale 1ns/1ps
module ctrl_master (
  input wire logic clk,
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_drv,
  output logic sda_drv
);
  int q = 8;
  int late = 0;
  initial scl_drv = 1'b1;
  initial sda_drv = 1'b1;
  // Waits out stretching but gives up so a stuck slave cannot hang us
  task automatic scl_high();
    int n;
    scl_drv <= 1'b1;
    @(posedge clk);
    for (n = 0; scl_w !== 1'b1 && n < 400; n++) @(posedge clk);
    if (n >= 400) late++;
    repeat (q) @(posedge clk);
  endtask
  task automatic put_bit(input logic b, output logic seen);
    sda_drv <= b;
    repeat (q) @(posedge clk);
    scl_high();
    seen = sda_w;
    scl_drv <= 1'b0;
    repeat (q) @(posedge clk);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic last,
      output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(last, s);
    ack = !s;
  endtask
  // Serves as the repeated start as well
  task automatic send_start();
    sda_drv <= 1'b1;
    repeat (q) @(posedge clk);
    scl_high();
    sda_drv <= 1'b0;
    repeat (q) @(posedge clk);
    scl_drv <= 1'b0;
    repeat (q) @(posedge clk);
  endtask
  task automatic send_stop();
    sda_drv <= 1'b0;
    repeat (q) @(posedge clk);
    scl_high();
    sda_drv <= 1'b1;
    repeat (q) @(posedge clk);
  endtask
endmodule // ctrl_master

// [bench/cmd_port_tb.sv]
/*
  Self-checking bench of the command port; firmware strobes come from here.
  Assumes pull-ups on both bus wires and the master model beside it.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("wrong value %s exp %0h seen %0h", nm, e, g); \
  end end
module cmd_port_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic core_enable_a = 1'b1;
  logic core_enable_b = 1'b1;
  logic cmd_taken = 1'b0;
  logic rd_load = 1'b0;
  logic [15:0] rd_word = 16'h0000;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, cmd_valid, rd_request;
  logic soft_reset, scl_drv, sda_drv;
  logic [15:0] cmd_word;
  logic [3:0] task_select_field;
  wire scl_w = scl_drv & scl_oe_n;
  wire sda_w = sda_drv & sda_oe_n;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_rst = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  cmd_port #(.RESP_MAX_CYC(200)) dut (.clk(clk), .reset_n(reset_n),
    .ce(ce), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .core_enable_a(core_enable_a), .core_enable_b(core_enable_b),
    .cmd_word(cmd_word), .cmd_valid(cmd_valid), .cmd_taken(cmd_taken),
    .rd_word(rd_word), .rd_load(rd_load), .rd_request(rd_request),
    .soft_reset(soft_reset), .task_select_field(task_select_field));
  ctrl_master m (.clk(clk), .scl_w(scl_w), .sda_w(sda_w),
    .scl_drv(scl_drv), .sda_drv(sda_drv));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (soft_reset === 1'b1) n_rst <= n_rst + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic head(input logic [7:0] a, s, output logic ka, ks);
    logic [7:0] rx;
    m.send_start();
    m.xfer(a, 1'b1, rx, ka);
    m.xfer(s, 1'b1, rx, ks);
  endtask
  task automatic word(input logic [15:0] w, input logic hl,
      output logic [15:0] rx, output logic k);
    logic k1;
    m.xfer(w[15:8], hl, rx[15:8], k1);
    m.xfer(w[7:0], 1'b1, rx[7:0], k);
    k = k & k1;
  endtask
  task automatic take();
    cmd_taken <= 1'b1;
    @(posedge clk);
    cmd_taken <= 1'b0;
  endtask
  task automatic test_write();
    logic a, b, k;
    logic [15:0] rx;
    head(8'h3A, 8'h68, a, b);
    word(16'h0FCD, 1'b1, rx, k);
    `CHK("acks", 3'b111, {a, b, k})
    `CHK("word", 17'h10FCD, {cmd_valid, cmd_word})
    // Second word must wait in a stretch until the first is taken
    fork
      word(16'h1234, 1'b1, rx, k);
      begin
        for (int i = 0; i < 900 && scl_oe_n !== 1'b0; i++) @(posedge clk);
        repeat (20) @(posedge clk);
        take();
      end
    join
    m.send_stop();
    `CHK("stretch", 18'h31234, {k, m.late == 0, cmd_word})
    take();
    repeat (2) @(posedge clk);
    `CHK("taken", 1'b0, cmd_valid)
    $display("test write done");
  endtask
  task automatic test_ctrl();
    logic a, b, k;
    logic [15:0] rx;
    head(8'h3A, 8'h6A, a, b);
    word(16'h0105, 1'b1, rx, k);
    m.send_stop();
    `CHK("task", 7'h75, {a, b, k, task_select_field})
    head(8'h3A, 8'h6A, a, b);
    word(16'hFE00, 1'b1, rx, k);
    m.send_stop();
    `CHK("task clear", 5'h10, {k, task_select_field})
    `CHK("pulses", 1, n_rst)
    `CHK("no data", 1'b0, cmd_valid)
    $display("test control done");
  endtask
  task automatic test_read();
    logic a, b, k, c;
    logic [7:0] x;
    logic [15:0] rx;
    // Memory read command first, then the block itself
    head(8'h3A, 8'h68, a, b);
    word(16'h3083, 1'b1, rx, k);
    m.send_stop();
    `CHK("command", 20'hF3083, {a, b, k, cmd_valid, cmd_word})
    // Firmware picks the command up before the master asks for data
    take();
    head(8'h3A, 8'h69, a, b);
    fork
      begin
        m.send_start();
        m.xfer(8'h3B, 1'b1, x, k);
        word(16'hFFFF, 1'b0, rx, c);
      end
      begin
        for (int i = 0; i < 900 && rd_request !== 1'b1; i++) @(posedge clk);
        repeat (20) @(posedge clk);
        rd_word <= 16'hA55A;
        rd_load <= 1'b1;
        @(posedge clk);
        rd_load <= 1'b0;
      end
    join
    m.send_stop();
    `CHK("read", 20'hFA55A, {a, b, k, m.late == 0, rx})
    $display("test read done");
  endtask
  // No word is ever loaded: the stretch must give up on its own
  task automatic test_timeout();
    logic a, b, k, c;
    logic [7:0] x;
    logic [15:0] rx;
    head(8'h3A, 8'h69, a, b);
    m.send_start();
    m.xfer(8'h3B, 1'b1, x, k);
    word(16'hFFFF, 1'b0, rx, c);
    m.send_stop();
    `CHK("timeout", 20'hFFFFF, {a, b, k, m.late == 0, rx})
    `CHK("req", 1'b0, rd_request)
    $display("test timeout done");
  endtask
  task automatic try(input logic [7:0] a, s, input logic [1:0] e);
    logic ka, ks;
    head(a, s, ka, ks);
    m.send_stop();
    `CHK("refusal", e, {ka, ks})
  endtask
  task automatic test_refuse();
    logic a, b, k;
    logic [7:0] x;
    try(8'h3C, 8'h68, 2'b00);
    try(8'h3A, 8'h6B, 2'b10);
    core_enable_b <= 1'b0;
    try(8'h3A, 8'h68, 2'b00);
    core_enable_b <= 1'b1;
    head(8'h3A, 8'h6A, a, b);
    m.send_start();
    m.xfer(8'h3B, 1'b1, x, k);
    m.send_stop();
    `CHK("ctrl read", 3'b110, {a, b, k})
    `CHK("untouched", 2'b01, {cmd_valid, n_rst == 1})
    $display("test refusal done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("idle oe", 2'b11, {scl_oe_n, sda_oe_n})
    `CHK("idle", 3'b000, {cmd_valid, rd_request, soft_reset})
    `CHK("pads", 2'b00, {scl_out, sda_out})
    test_write();
    test_ctrl();
    test_read();
    test_timeout();
    test_refuse();
    test_done();
  end
endmodule // cmd_port_tb
